// ===== dmd_consts.vh
`ifndef DMD_CONSTS_VH
`define DMD_CONSTS_VH
// ==========================================================
// Address map bases
`define DMD_PRIV_RAM_BASE 32'h0000_0000
`define DMD_RAM_END_64K 32'h0000_FFFF
`define DMD_RAM_END_96K 32'h0001_7FFF
`define DMD_RAM_END_128K 32'h0001_FFFF
`define DMD_TCF_LARGE_BASE 32'h0080_0000
`define DMD_FL_END_512K 32'h0007_FFFF
`define DMD_FL_END_768K 32'h000B_FFFF
`define DMD_FL_END_1024K 32'h000F_FFFF
`define DMD_TCF_SMALL_BASE 32'h00FE_0000
`define DMD_SMALL_SPAN 32'h0001_FFFF
`define DMD_AXF_LARGE_BASE 32'h0100_0000
`define DMD_AXF_SMALL_BASE 32'h01FE_0000
`define DMD_EXCL_BASE 32'h0280_0000
`define DMD_EXCL_END 32'h0280_0FFF
`define DMD_CPU0_ALIAS 32'h0400_0000
`define DMD_CPU1_ALIAS 32'h0600_0000
`define DMD_ALIAS_SPAN 32'h0200_0000
`define DMD_EXEMPT_LO 32'h1000_0000
`define DMD_EXEMPT_HI 32'h2FFF_FFFF
`define DMD_GAP_LO 32'h0010_0000
`define DMD_GAP_HI 32'h00FD_FFFF
`define DMD_CPU1_GAP_LO 32'h0710_0000
`define DMD_CPU1_GAP_HI 32'h07FD_FFFF
// ==========================================================
// Targets, response codes and size codes
`define DMD_TGT_NONE 3'h0
`define DMD_TGT_RAM 3'h1
`define DMD_TGT_TCF 3'h2
`define DMD_TGT_AXF 3'h3
`define DMD_TGT_EXCL 3'h4
`define DMD_TGT_OKAY 3'h5
`define DMD_TGT_ERR 3'h6
`define DMD_RESP_OKAY 2'h0
`define DMD_RESP_DECERR 2'h3
`define DMD_SIZE_SMALL 2'h0
`define DMD_SIZE_MID 2'h1
`define DMD_SIZE_LARGE 2'h2
`endif

// ===== dmd_map_decoder.v
`timescale 1ns/1ns
`include "dmd_consts.vh"
// Contract
// - Private coupled RAM from zero, end set by RAM size variant.
// - Coupled large flash from 0x0080_0000, end set by flash size.
// - Coupled small flash occupies 0x00FE_0000 to 0x00FF_FFFF.
// - AXI-side large flash from 0x0100_0000, end set by flash size.
// - AXI-side small flash decoded at 0x01FE_0000 to 0x01FF_FFFF.
// - Exclusive access memory at 0x0280_0000 to 0x0280_0FFF; rest reserved.
// - CPU0 memories alias in common space from 0x0400_0000.
// - CPU1 RAM, coupled flash and AXI-side flash alias from 0x0600_0000.
// - Private space unreachable by other masters; they use aliases.
// - Non-exempt reserved access answered with bus error.
// - Listed flash gaps and 0x1000_0000..0x2FFF_FFFF complete without error.
// - Each master carries a distinct ID; one transaction at a time, so completions stay in order.
module dmd_map_decoder #(
   parameter ID_W = 4,
   parameter MST_W = 2,
   parameter [MST_W-1:0] CPU0_MASTER = 2'h0,
   parameter [MST_W-1:0] CPU1_MASTER = 2'h1
)
(
   input wire mclk,
   input wire reset_n,
   input wire [1:0] ram_size,
   input wire [1:0] flash_size,
   input wire req_valid,
   input wire [31:0] req_addr,
   input wire req_write,
   input wire [MST_W-1:0] req_master,
   input wire [ID_W-1:0] req_tag,
   output reg req_ready,
   input wire resp_ready,
   output wire resp_valid,
   output wire [1:0] resp_code,
   output wire [ID_W+MST_W-1:0] resp_id,
   output reg sel_valid,
   output reg [2:0] sel_target,
   output reg sel_cpu,
   output reg [31:0] sel_offset,
   output reg sel_write,
   output reg [ID_W+MST_W-1:0] sel_id,
   input wire sel_done
);
   localparam ST_IDLE = 2'h0;
   localparam ST_MEM = 2'h1;
   localparam ST_RESP = 2'h2;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [1:0] size_ram;
   reg [1:0] size_flash;
   wire [2:0] dec_target;
   wire dec_cpu;
   wire [31:0] dec_offset;
   wire is_owner;
   wire owner_id;
   wire accept;
   wire mem_target;
   wire [ID_W+MST_W-1:0] full_id;
   wire load_resp;
   wire [1:0] load_code;
   // ==========================================================
   // Owner CPU detection: only a CPU may use its own private space
   assign is_owner = (req_master == CPU0_MASTER) || (req_master == CPU1_MASTER);
   assign owner_id = (req_master == CPU1_MASTER);
   // Master number widens the ID so every master stays distinct
   assign full_id = {req_master, req_tag};
   assign accept = req_valid && req_ready;
   assign mem_target = (dec_target == `DMD_TGT_RAM) || (dec_target == `DMD_TGT_TCF)
      || (dec_target == `DMD_TGT_AXF) || (dec_target == `DMD_TGT_EXCL);
   dmd_region_decode u_dec
   (
      .addr(req_addr),
      .ram_size(size_ram),
      .flash_size(size_flash),
      .is_owner_cpu(is_owner),
      .owner_id(owner_id),
      .target(dec_target),
      .target_cpu(dec_cpu),
      .offset(dec_offset)
   );
   // ==========================================================
   // Size straps registered on every clock, in reset or not; stable in use
   always @(posedge mclk)
   begin
      size_ram <= ram_size;
      size_flash <= flash_size;
   end
   // ==========================================================
   // Sequencer: one transaction in flight keeps answers simple
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (accept)
               next_state = mem_target ? ST_MEM : ST_RESP;
         ST_MEM:
            if (sel_done)
               next_state = ST_RESP;
         ST_RESP:
            if (resp_valid && resp_ready)
               next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end
   always @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state <= ST_IDLE;
         req_ready <= 1'b0;
         sel_valid <= 1'b0;
         sel_target <= `DMD_TGT_NONE;
         sel_cpu <= 1'b0;
         sel_offset <= 32'h0000_0000;
         sel_write <= 1'b0;
         sel_id <= {(ID_W+MST_W){1'b0}};
      end
      else
      begin
         state <= next_state;
         req_ready <= (next_state == ST_IDLE) && !accept;
         if (accept)
         begin
            sel_id <= full_id;
            sel_target <= dec_target;
            sel_cpu <= dec_cpu;
            sel_offset <= dec_offset;
            sel_write <= req_write;
            sel_valid <= mem_target; // error never strobes memory
         end
         else if (sel_done)
            sel_valid <= 1'b0;
      end
   end
   // ==========================================================
   // Answer: reserved non-exempt gives DECERR, others OKAY
   assign load_resp = (accept && !mem_target) || (state == ST_MEM && sel_done);
   assign load_code = (state == ST_IDLE && dec_target == `DMD_TGT_ERR)
      ? `DMD_RESP_DECERR : `DMD_RESP_OKAY;
   dmd_resp_hold #(
      .ID_W(ID_W+MST_W)
   ) u_resp
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .load(load_resp),
      .load_resp(load_code),
      .load_id((state == ST_IDLE) ? full_id : sel_id),
      .take(resp_ready),
      .valid(resp_valid),
      .resp(resp_code),
      .id(resp_id)
   );
endmodule // dmd_map_decoder

// ===== dmd_map_decoder_properties.sv
`timescale 1ns/1ns
`include "dmd_consts.vh"
// ==========================================================
// Port-level checks of the map decoder
module dmd_map_decoder_properties #(
   parameter ID_W = 4,
   parameter MST_W = 2
)
(
   input wire mclk,
   input wire reset_n,
   input wire req_valid,
   input wire [31:0] req_addr,
   input wire [MST_W-1:0] req_master,
   input wire req_ready,
   input wire resp_ready,
   input wire resp_valid,
   input wire [1:0] resp_code,
   input wire sel_valid,
   input wire [2:0] sel_target,
   input wire sel_cpu,
   input wire [31:0] sel_offset,
   input wire sel_done
);
   // Accepted request
   wire take = req_valid && req_ready;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   chk_busy_refuse:
      assert property ((sel_valid || resp_valid) |-> !req_ready) else $error("ready while busy");
   chk_resp_stands:
      assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_code))
      else $error("answer dropped early");
   chk_sel_stands:
      assert property (sel_valid && !sel_done |=> sel_valid && $stable(sel_offset))
      else $error("selection dropped early");
   chk_done_okay:
      assert property (sel_valid && sel_done |=> resp_valid && resp_code == `DMD_RESP_OKAY)
      else $error("no answer after done");
   chk_err_no_mem:
      assert property (resp_valid && resp_code == `DMD_RESP_DECERR |-> !sel_valid)
      else $error("memory touched on error");
   chk_other_private:
      assert property (take && req_master > 1 && req_addr < 32'h0280_0000
         |=> resp_valid && resp_code == `DMD_RESP_DECERR) else $error("private leak");
   chk_exempt_okay:
      assert property (take && req_addr >= 32'h1000_0000 && req_addr <= 32'h2FFF_FFFF
         |=> resp_valid && resp_code == 2'h0 && !sel_valid) else $error("exempt failed");
   chk_excl_select:
      assert property (take && req_addr >= 32'h0280_0000 && req_addr <= 32'h0280_0FFF
         |=> sel_valid && sel_target == 3'h4 && sel_offset == $past(req_addr) - 32'h0280_0000)
      else $error("exclusive memory missed");
   chk_high_error:
      assert property (take && req_addr >= 32'h3000_0000
         |=> resp_valid && resp_code == `DMD_RESP_DECERR) else $error("high area accepted");
   chk_small_flash:
      assert property (take && req_master < 2 && req_addr[31:17] == 15'h007F
         |=> sel_valid && sel_target == 3'h2 && sel_cpu == $past(req_master[0]))
      else $error("small flash missed");
endmodule // dmd_map_decoder_properties
bind dmd_map_decoder dmd_map_decoder_properties #(.ID_W(ID_W), .MST_W(MST_W))
   u_dmd_map_decoder_properties (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
   .req_addr(req_addr), .req_master(req_master), .req_ready(req_ready),
   .resp_ready(resp_ready), .resp_valid(resp_valid), .resp_code(resp_code),
   .sel_valid(sel_valid), .sel_target(sel_target), .sel_cpu(sel_cpu),
   .sel_offset(sel_offset), .sel_done(sel_done));

// ===== dmd_map_decoder_tb.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench of the map decoder
module dmd_map_decoder_tb;
   reg mclk = 1'b0;
   reg reset_n = 1'b0;
   reg [1:0] ram_size = 2'h0;
   reg [1:0] flash_size = 2'h0;
   reg req_valid = 1'b0;
   reg [31:0] req_addr = 32'h0;
   reg req_write = 1'b0;
   reg [1:0] req_master = 2'h0;
   reg [3:0] req_tag = 4'h0;
   reg resp_ready = 1'b0;
   reg [3:0] mem_wait = 4'h0;
   wire req_ready, resp_valid, sel_valid, sel_cpu, sel_write, sel_done;
   wire [1:0] resp_code;
   wire [5:0] resp_id, sel_id;
   wire [2:0] sel_target;
   wire [31:0] sel_offset;
   integer bad_count = 0;
   integer checks = 0;
   dmd_map_decoder u_dmd_map_decoder (.mclk(mclk), .reset_n(reset_n), .ram_size(ram_size),
      .flash_size(flash_size), .req_valid(req_valid), .req_addr(req_addr),
      .req_write(req_write), .req_master(req_master), .req_tag(req_tag),
      .req_ready(req_ready), .resp_ready(resp_ready), .resp_valid(resp_valid),
      .resp_code(resp_code), .resp_id(resp_id), .sel_valid(sel_valid),
      .sel_target(sel_target), .sel_cpu(sel_cpu), .sel_offset(sel_offset),
      .sel_write(sel_write), .sel_id(sel_id), .sel_done(sel_done));
   dmd_mem_model u_dmd_mem_model (.mclk(mclk), .reset_n(reset_n), .sel_valid(sel_valid),
      .wait_cycles(mem_wait), .sel_done(sel_done));
   always #20 mclk = ~mclk;
   task final_report;
   begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   task cmp(input [95:0] n, input [31:0] e, input [31:0] g);
   begin
      checks = checks + 1;
      if (g !== e)
      begin
         bad_count = bad_count + 1;
         $display("unexpected %0s expected %h seen %h", n, e, g);
      end
   end
   endtask
   // One request; selection seen is {cpu, target}, zero when no memory
   // Strictly one request at a time, in order, as ordered accesses need
   task acc(input [1:0] m, input [31:0] a, input [1:0] c, input [3:0] ct, input [31:0] o);
      integer n;
      reg [3:0] sct;
      reg [31:0] soff;
      reg [5:0] sid;
      reg swr;
   begin
      sct = 4'h0;
      soff = 32'h0;
      sid = 6'h00;
      swr = 1'b0;
      n = 0;
      req_master = m;
      req_addr = a;
      req_tag = a[5:2];
      req_write = a[4];
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 50)
      begin
         @(posedge mclk);
         #1;
         n = n + 1;
      end
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      while (resp_valid !== 1'b1 && n < 100)
      begin
         if (sel_valid === 1'b1)
         begin
            sct = {sel_cpu, sel_target};
            soff = sel_offset;
            sid = sel_id;
            swr = sel_write;
         end
         @(posedge mclk);
         #1;
         n = n + 1;
      end
      cmp("resp_valid", 32'h1, {31'h0, resp_valid});
      cmp("resp_code", {30'h0, c}, {30'h0, resp_code});
      cmp("selection", {28'h0, ct}, {28'h0, sct});
      cmp("offset", o, soff);
      cmp("resp_id", {26'h0, m, a[5:2]}, {26'h0, resp_id});
      cmp("sel_id", (ct == 4'h0) ? 32'h0 : {26'h0, m, a[5:2]}, {26'h0, sid});
      cmp("sel_write", (ct == 4'h0) ? 32'h0 : {31'h0, a[4]}, {31'h0, swr});
      // Answer left waiting one cycle before it is taken
      @(posedge mclk);
      #1;
      resp_ready = 1'b1;
      @(posedge mclk);
      #1;
      resp_ready = 1'b0;
   end
   endtask
   task s_sizes;
      integer i;
      reg [31:0] e;
      reg [31:0] f;
   begin
      for (i = 0; i < 3; i = i + 1)
      begin
         ram_size = i[1:0];
         flash_size = i[1:0];
         mem_wait = i[3:0] * 4'h3;
         e = (i == 0) ? 32'h0000_FFFF : (i == 1) ? 32'h0001_7FFF : 32'h0001_FFFF;
         f = (i == 0) ? 32'h0007_FFFF : (i == 1) ? 32'h000B_FFFF : 32'h000F_FFFF;
         repeat (2) @(posedge mclk);
         #1;
         acc(2'h0, e, 2'h0, 4'h1, e);
         acc(2'h0, e + 32'h1, 2'h3, 4'h0, 32'h0);
         acc(2'h0, 32'h0080_0000 + f, 2'h0, 4'h2, f);
         acc(2'h0, 32'h0080_0001 + f, (i == 2) ? 2'h0 : 2'h3, 4'h0, 32'h0);
         acc(2'h1, 32'h0100_0000 + f, 2'h0, 4'hB, f);
      end
   end
   endtask
   task s_map;
   begin
      acc(2'h0, 32'h00FE_0000, 2'h0, 4'h2, 32'h00FE_0000);
      acc(2'h1, 32'h01FF_FFFC, 2'h0, 4'hB, 32'h00FF_FFFC);
      acc(2'h0, 32'h0280_0FFC, 2'h0, 4'h4, 32'h0000_0FFC);
      acc(2'h0, 32'h0280_1000, 2'h3, 4'h0, 32'h0);
      acc(2'h2, 32'h0400_0010, 2'h0, 4'h1, 32'h10);
      acc(2'h3, 32'h0500_0000, 2'h0, 4'h3, 32'h0);
      acc(2'h2, 32'h04FE_0000, 2'h0, 4'h2, 32'h00FE_0000);
      acc(2'h2, 32'h0600_0010, 2'h0, 4'h9, 32'h10);
      acc(2'h2, 32'h0680_0004, 2'h0, 4'hA, 32'h4);
      acc(2'h2, 32'h0000_0010, 2'h3, 4'h0, 32'h0);
      acc(2'h3, 32'h0080_0000, 2'h3, 4'h0, 32'h0);
      acc(2'h1, 32'h0000_0010, 2'h0, 4'h9, 32'h10);
   end
   endtask
   task s_reserved;
   begin
      acc(2'h0, 32'h0110_0000, 2'h0, 4'h0, 32'h0);
      acc(2'h2, 32'h0490_0000, 2'h0, 4'h0, 32'h0);
      acc(2'h2, 32'h0510_0000, 2'h0, 4'h0, 32'h0);
      acc(2'h2, 32'h0690_0000, 2'h0, 4'h0, 32'h0);
      acc(2'h2, 32'h0710_0000, 2'h0, 4'h0, 32'h0);
      acc(2'h2, 32'h1000_0000, 2'h0, 4'h0, 32'h0);
      acc(2'h3, 32'h2FFF_FFFC, 2'h0, 4'h0, 32'h0);
      acc(2'h0, 32'h0200_0000, 2'h3, 4'h0, 32'h0);
      acc(2'h2, 32'h0800_0000, 2'h3, 4'h0, 32'h0);
      acc(2'h2, 32'h3000_0000, 2'h3, 4'h0, 32'h0);
   end
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      s_sizes;
      s_map;
      s_reserved;
      final_report;
   end
   // Hang guard, well above the few hundred cycles the tests need
   initial
   begin
      #200000;
      bad_count = bad_count + 1;
      final_report;
   end
endmodule // dmd_map_decoder_tb

// ===== dmd_mem_model.sv
`timescale 1ns/1ns
// ==========================================================
// Memory side stand-in: answers each selection after a set wait
module dmd_mem_model
(
   input wire mclk,
   input wire reset_n,
   input wire sel_valid,
   input wire [3:0] wait_cycles,
   output reg sel_done
);
   reg [3:0] count;
   // One-cycle done pulse; cleared while idle so no stale answer leaks
   always @(posedge mclk)
   begin
      if (!reset_n || !sel_valid || sel_done)
      begin
         count <= 4'h0;
         sel_done <= 1'b0;
      end
      else if (count == wait_cycles)
         sel_done <= 1'b1;
      else
         count <= count + 4'h1;
   end
endmodule // dmd_mem_model

// ===== dmd_region_decode.v
`timescale 1ns/1ns
`include "dmd_consts.vh"
// Combinational classification of one address
module dmd_region_decode
(
   input wire [31:0] addr,
   input wire [1:0] ram_size,
   input wire [1:0] flash_size,
   input wire is_owner_cpu,
   input wire owner_id,
   output reg [2:0] target,
   output reg target_cpu,
   output reg [31:0] offset
);
   reg [31:0] ram_end;
   reg [31:0] fl_end;
   reg [31:0] loc;
   reg alias_hit;
   reg alias_cpu;
   // ==========================================================
   // Size variant ends
   always @*
   begin
      case (ram_size)
         `DMD_SIZE_SMALL: ram_end = `DMD_RAM_END_64K;
         `DMD_SIZE_MID: ram_end = `DMD_RAM_END_96K;
         default: ram_end = `DMD_RAM_END_128K;
      endcase
      case (flash_size)
         `DMD_SIZE_SMALL: fl_end = `DMD_FL_END_512K;
         `DMD_SIZE_MID: fl_end = `DMD_FL_END_768K;
         default: fl_end = `DMD_FL_END_1024K;
      endcase
   end
   // ==========================================================
   // Region match; private space folds onto same layout as aliases
   always @*
   begin
      alias_hit = 1'b0;
      alias_cpu = 1'b0;
      loc = addr;
      target = `DMD_TGT_ERR;
      target_cpu = owner_id;
      offset = 32'h0000_0000;
      if (addr >= `DMD_CPU0_ALIAS && addr < `DMD_CPU1_ALIAS)
      begin
         alias_hit = 1'b1;
         loc = addr - `DMD_CPU0_ALIAS;
      end
      else if (addr >= `DMD_CPU1_ALIAS && addr < `DMD_CPU1_ALIAS + `DMD_ALIAS_SPAN)
      begin
         alias_hit = 1'b1;
         alias_cpu = 1'b1;
         loc = addr - `DMD_CPU1_ALIAS;
      end
      if (alias_hit)
         target_cpu = alias_cpu;
      // Private space only for its own CPU; others see reserved
      if (!alias_hit && addr < `DMD_EXCL_BASE && !is_owner_cpu)
         target = `DMD_TGT_ERR;
      else if (loc <= ram_end && (alias_hit || addr < `DMD_EXCL_BASE))
      begin
         target = `DMD_TGT_RAM;
         offset = loc;
      end
      else if (loc >= `DMD_TCF_LARGE_BASE && loc <= `DMD_TCF_LARGE_BASE + fl_end)
      begin
         target = `DMD_TGT_TCF;
         offset = loc - `DMD_TCF_LARGE_BASE;
      end
      else if (loc >= `DMD_TCF_SMALL_BASE && loc <= `DMD_TCF_SMALL_BASE + `DMD_SMALL_SPAN)
      begin
         target = `DMD_TGT_TCF;
         offset = loc - `DMD_TCF_SMALL_BASE + `DMD_TCF_SMALL_BASE;
      end
      else if (loc >= `DMD_AXF_LARGE_BASE && loc <= `DMD_AXF_LARGE_BASE + fl_end)
      begin
         target = `DMD_TGT_AXF;
         offset = loc - `DMD_AXF_LARGE_BASE;
      end
      else if (loc >= `DMD_AXF_SMALL_BASE && loc <= `DMD_AXF_SMALL_BASE + `DMD_SMALL_SPAN)
      begin
         target = `DMD_TGT_AXF;
         offset = loc - `DMD_AXF_SMALL_BASE + `DMD_TCF_SMALL_BASE;
      end
      else if (!alias_hit && addr >= `DMD_EXCL_BASE && addr <= `DMD_EXCL_END)
      begin
         target = `DMD_TGT_EXCL;
         offset = addr - `DMD_EXCL_BASE;
      end
      // Exempt holes: flash gaps in every space, plus the wide span
      else if ((loc >= `DMD_TCF_LARGE_BASE + `DMD_GAP_LO
                && loc <= `DMD_GAP_HI)
               || (loc >= `DMD_AXF_LARGE_BASE + `DMD_GAP_LO
                && loc <= `DMD_AXF_LARGE_BASE + `DMD_GAP_HI)
               || (addr >= `DMD_CPU1_GAP_LO && addr <= `DMD_CPU1_GAP_HI)
               || (addr >= `DMD_EXEMPT_LO && addr <= `DMD_EXEMPT_HI))
         target = `DMD_TGT_OKAY;
      else
         target = `DMD_TGT_ERR;
   end
endmodule // dmd_region_decode

// ===== dmd_resp_hold.v
`timescale 1ns/1ns
`include "dmd_consts.vh"
// Holds one registered answer until the master accepts it
module dmd_resp_hold #(
   parameter ID_W = 4
)
(
   input wire mclk,
   input wire reset_n,
   input wire load,
   input wire [1:0] load_resp,
   input wire [ID_W-1:0] load_id,
   input wire take,
   output reg valid,
   output reg [1:0] resp,
   output reg [ID_W-1:0] id
);
   // ==========================================================
   // Answer register
   always @(posedge mclk)
   begin
      if (!reset_n)
      begin
         valid <= 1'b0;
         resp <= `DMD_RESP_OKAY;
         id <= {ID_W{1'b0}};
      end
      else if (load)
      begin
         valid <= 1'b1;
         resp <= load_resp;
         id <= load_id;
      end
      else if (take)
         valid <= 1'b0;
   end
endmodule // dmd_resp_hold
